// ---- core/interrupt_vector_map.sv ----
`timescale 1ns/1ns
module interrupt_vector_map #(
  parameter int unsigned NSRC = vector_map_pkg::NUM_USED
) (
  // Clock and reset
  input  wire logic                                clk_i,
  input  wire logic                                rst_i,
  input  wire logic                                ce_i,
  // Configuration
  input  wire logic [vector_map_pkg::ADDR_W-1:0]   vector_base_i,
  input  wire logic [1:0]                          mask_i,
  input  wire logic [2*NSRC-1:0]                   priority_level_i,
  // Interrupt sources
  input  wire logic [NSRC-1:0]                     pend_i,
  input  wire logic                                host_pend_i,
  input  wire logic                                host_nmi_i,
  input  wire logic                                host_use_default_i,
  input  wire logic [vector_map_pkg::HOST_VEC_W-1:0] host_vec_i,
  // Program control unit
  input  wire logic                                fetch_ready_i,
  output logic                                     fetch_valid_o,
  output logic [vector_map_pkg::ADDR_W-1:0]        fetch_addr_o,
  output logic                                     fetch_last_o,
  output logic [vector_map_pkg::LVL_W-1:0]         priority_level_o,
  output logic [NSRC-1:0]                          ack_o,
  output logic                                     host_ack_o
);
  vec_req_if win ();

  logic [vector_map_pkg::HOST_VEC_W-1:0] hvec;
  assign hvec = host_use_default_i ?
                vector_map_pkg::HOST_CMD_DEFAULT : host_vec_i;

  vector_arbiter #(.NSRC(NSRC)) u_arb (
    .pend_i      (pend_i),
    .level_i     (priority_level_i),
    .mask_i      (mask_i),
    .host_pend_i (host_pend_i),
    .host_vec_i  (hvec),
    .host_nmi_i  (host_nmi_i),
    .win         (win)
  );

  function automatic logic [vector_map_pkg::ADDR_W-1:0] entry_addr(
    input logic [vector_map_pkg::ADDR_W-1:0] base,
    input logic [vector_map_pkg::OFF_W-1:0]  off);
    // Offsets stay inside the 256-word window above the base
    entry_addr = base + {{(vector_map_pkg::ADDR_W-vector_map_pkg::OFF_W){1'b0}},
                         off};
  endfunction : entry_addr

  function automatic logic [NSRC-1:0] ack_of(
    input logic [vector_map_pkg::OFF_W-1:0] off);
    ack_of = '0;
    for (int i = 0; i < int'(NSRC); i++) begin
      if (vector_map_pkg::FIXED_OFFSET[i] == off) begin
        ack_of[i] = 1'b1;
      end
    end
  endfunction : ack_of

  vector_map_pkg::fetch_state_t st_q, st_d;
  logic [vector_map_pkg::ADDR_W-1:0] addr_q, addr_d;
  logic [vector_map_pkg::LVL_W-1:0]  lvl_q, lvl_d;
  logic                              last_q, last_d;
  logic                              valid_q, valid_d;
  logic [NSRC-1:0]                   ack_q, ack_d;
  logic                              hack_q, hack_d;
  logic                              from_host;

  // Host owns the winner unless a pending fixed source shares its offset
  assign from_host = host_pend_i && (win.offset == {hvec, 1'b0}) &&
                     ((ack_of(win.offset) & pend_i) == '0);

  always_comb begin
    st_d    = st_q;
    addr_d  = addr_q;
    lvl_d   = lvl_q;
    last_d  = last_q;
    valid_d = valid_q;
    ack_d   = '0;
    hack_d  = 1'b0;
    unique case (st_q)
      vector_map_pkg::ST_IDLE: begin
        if (win.valid) begin
          addr_d  = entry_addr(vector_base_i, win.offset);
          lvl_d   = win.level;
          valid_d = 1'b1;
          last_d  = 1'b0;
          st_d    = vector_map_pkg::ST_WORD0;
          if (from_host) begin
            hack_d = 1'b1;
          end else begin
            ack_d = ack_of(win.offset) & pend_i;
          end
        end
      end
      vector_map_pkg::ST_WORD0: begin
        if (fetch_ready_i) begin
          // Second instruction of the two-word entry
          addr_d = addr_q + {{(vector_map_pkg::ADDR_W-1){1'b0}}, 1'b1};
          last_d = 1'b1;
          st_d   = vector_map_pkg::ST_WORD1;
        end
      end
      vector_map_pkg::ST_WORD1: begin
        if (fetch_ready_i) begin
          valid_d = 1'b0;
          last_d  = 1'b0;
          st_d    = vector_map_pkg::ST_IDLE;
        end
      end
      default: begin
        st_d    = vector_map_pkg::ST_IDLE;
        valid_d = 1'b0;
      end
    endcase
  end

  // Only fetches are issued; table contents stay ordinary memory
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q    <= vector_map_pkg::ST_IDLE;
      addr_q  <= '0;
      lvl_q   <= vector_map_pkg::LVL_MIN;
      last_q  <= 1'b0;
      valid_q <= 1'b0;
      ack_q   <= '0;
      hack_q  <= 1'b0;
    end else if (ce_i) begin
      st_q    <= st_d;
      addr_q  <= addr_d;
      lvl_q   <= lvl_d;
      last_q  <= last_d;
      valid_q <= valid_d;
      ack_q   <= ack_d;
      hack_q  <= hack_d;
    end
  end

  assign fetch_valid_o    = valid_q;
  assign fetch_addr_o     = addr_q;
  assign fetch_last_o     = last_q;
  assign priority_level_o = lvl_q;
  assign ack_o            = ack_q;
  assign host_ack_o       = hack_q;
endmodule : interrupt_vector_map

// ---- core/vec_req_if.sv ----
`timescale 1ns/1ns
interface vec_req_if;
  logic                                   valid;
  logic [vector_map_pkg::OFF_W-1:0]       offset;
  logic [vector_map_pkg::LVL_W-1:0]       level;
  modport arb (output valid, output offset, output level);
  modport top (input valid, input offset, input level);
endinterface : vec_req_if

// ---- core/vector_arbiter.sv ----
`timescale 1ns/1ns
module vector_arbiter #(
  parameter int unsigned NSRC = vector_map_pkg::NUM_USED
) (
  // Sources
  input  wire logic [NSRC-1:0]                     pend_i,
  input  wire logic [2*NSRC-1:0]                   level_i,
  input  wire logic [1:0]                          mask_i,
  // Host-directed reserved vector
  input  wire logic                                host_pend_i,
  input  wire logic [vector_map_pkg::HOST_VEC_W-1:0] host_vec_i,
  input  wire logic                                host_nmi_i,
  // Winner
  vec_req_if.arb                                   win
);
  function automatic logic lvl_ok(input logic [1:0] l, input logic [1:0] m);
    lvl_ok = (l == vector_map_pkg::LVL_MAX) || (l > m) ||
             ((m == vector_map_pkg::LVL_MIN) && (l == m));
  endfunction : lvl_ok

  logic [1:0] lvl;
  logic [1:0] hl;
  always_comb begin
    win.valid  = 1'b0;
    win.offset = vector_map_pkg::OFF_NONE;
    win.level  = vector_map_pkg::LVL_MIN;
    lvl        = vector_map_pkg::LVL_MIN;
    hl = host_nmi_i ? vector_map_pkg::LVL_MAX : vector_map_pkg::LVL_HOST;
    if (host_pend_i && lvl_ok(hl, mask_i)) begin
      win.valid  = 1'b1;
      win.offset = {host_vec_i, 1'b0};
      win.level  = hl;
    end
    for (int i = NSRC - 1; i >= 0; i--) begin
      // Level-three sources are fixed at 3, the rest programmable 0..2
      if (i < int'(vector_map_pkg::NUM_LVL3)) begin
        lvl = vector_map_pkg::LVL_MAX;
      end else begin
        lvl = (level_i[2*i +: 2] == vector_map_pkg::LVL_MAX) ?
              vector_map_pkg::LVL_HOST : level_i[2*i +: 2];
      end
      if (pend_i[i] && lvl_ok(lvl, mask_i) &&
          (!win.valid || lvl >= win.level)) begin
        win.valid  = 1'b1;
        win.offset = vector_map_pkg::FIXED_OFFSET[i];
        win.level  = lvl;
      end
    end
  end
endmodule : vector_arbiter

// ---- core/vector_map_pkg.sv ----
package vector_map_pkg;
  localparam int unsigned ADDR_W        = 24;
  localparam int unsigned NUM_ENTRIES   = 128;
  localparam int unsigned TABLE_SPAN    = 256;
  localparam int unsigned ENTRY_WORDS   = 2;
  localparam int unsigned NUM_FIXED     = 47;
  localparam int unsigned SRC_W         = 6;
  localparam int unsigned OFF_W         = 8;
  localparam int unsigned LVL_W         = 2;
  localparam int unsigned HOST_VEC_W    = 7;

  localparam logic [LVL_W-1:0] LVL_MAX  = 2'h3;
  localparam logic [LVL_W-1:0] LVL_HOST = 2'h2;
  localparam logic [LVL_W-1:0] LVL_MIN  = 2'h0;

  localparam logic [HOST_VEC_W-1:0] HOST_CMD_DEFAULT = 7'h32;
  localparam logic [OFF_W-1:0] OFF_NONE = 8'hFF;

  // Table offset per fixed source, in priority order within each band
  localparam logic [OFF_W-1:0] FIXED_OFFSET [NUM_FIXED] = '{
    8'h00, 8'h02, 8'h04, 8'h06, 8'h08, 8'h0A,
    8'h10, 8'h12, 8'h14, 8'h16,
    8'h18, 8'h1A, 8'h1C, 8'h1E, 8'h20, 8'h22,
    8'h64, 8'h62, 8'h60,
    8'h32, 8'h30, 8'h34, 8'h38, 8'h3A, 8'h36,
    8'h42, 8'h40, 8'h44, 8'h48, 8'h4A, 8'h46,
    8'h52, 8'h50, 8'h54, 8'h56, 8'h58,
    8'h26, 8'h24, 8'h2A, 8'h28, 8'h2E, 8'h2C,
    8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF
  };
  localparam int unsigned NUM_LVL3 = 6;
  localparam int unsigned NUM_USED = 42;
  localparam int unsigned HOST_CMD_IDX = 16;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WORD0 = 2'b01,
    ST_WORD1 = 2'b10
  } fetch_state_t;
endpackage : vector_map_pkg

// ---- testbench/interrupt_vector_map_asserts.sv ----
`timescale 1ns/1ns
module interrupt_vector_map_asserts #(
  parameter int unsigned NSRC = vector_map_pkg::NUM_USED
) (
  input wire logic            clk_i,
  input wire logic            rst_i,
  input wire logic            ce_i,
  input wire logic [23:0]     vector_base_i,
  input wire logic [1:0]      mask_i,
  input wire logic            fetch_ready_i,
  input wire logic            fetch_valid_o,
  input wire logic [23:0]     fetch_addr_o,
  input wire logic            fetch_last_o,
  input wire logic [1:0]      priority_level_o,
  input wire logic [NSRC-1:0] ack_o,
  input wire logic            host_ack_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic [23:0] off;
  logic        hi;
  assign off = fetch_addr_o - vector_base_i;
  assign hi  = ack_o[NSRC-1:6] != '0;
  property p_take; $rose(fetch_valid_o) |-> ack_o != '0 || host_ack_o;
  endproperty
  a_take: assert property (p_take) else $error("fetch without ack");
  property p_pair; ce_i && fetch_valid_o && !fetch_last_o && fetch_ready_i
    |=> fetch_last_o && fetch_addr_o == $past(fetch_addr_o) + 24'h1;
  endproperty
  a_pair: assert property (p_pair) else $error("bad second word");
  property p_end; ce_i && fetch_last_o && fetch_ready_i |=> !fetch_valid_o;
  endproperty
  a_end: assert property (p_end) else $error("entry too long");
  property p_freeze; !ce_i |=> $stable(fetch_valid_o) &&
    $stable(fetch_addr_o) && $stable(ack_o) && $stable(host_ack_o);
  endproperty
  a_freeze: assert property (p_freeze) else $error("state moved");
  property p_hold; fetch_valid_o && !fetch_ready_i |=>
    fetch_valid_o && $stable(fetch_addr_o); endproperty
  a_hold: assert property (p_hold) else $error("word dropped");
  property p_even; host_ack_o || ack_o != '0 |-> !off[0] && !fetch_last_o;
  endproperty
  a_even: assert property (p_even) else $error("odd entry");
  property p_span; fetch_valid_o |-> off < 24'h100; endproperty
  a_span: assert property (p_span) else $error("out of table");
  property p_rsv; ack_o != '0 |-> off < 24'h66 && !(off inside {24'h0C,
    24'h0E, 24'h3C, 24'h3E, 24'h4C, 24'h4E, 24'h5A, 24'h5C, 24'h5E});
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved offset");
  property p_lvl3; ack_o[5:0] != '0 |-> priority_level_o == 2'h3; endproperty
  a_lvl3: assert property (p_lvl3) else $error("fixed level");
  property p_mask; hi |-> priority_level_o != 2'h3 &&
    ($past(mask_i) == 2'h0 || priority_level_o > $past(mask_i)); endproperty
  a_mask: assert property (p_mask) else $error("masked taken");
  c_host: cover property (host_ack_o);
  c_stall: cover property (fetch_valid_o && !fetch_ready_i);
  c_low: cover property (hi && priority_level_o == 2'h0);
endmodule : interrupt_vector_map_asserts

bind interrupt_vector_map interrupt_vector_map_asserts #(.NSRC(NSRC)) chk_u (
  .clk_i, .rst_i, .ce_i, .vector_base_i, .mask_i, .fetch_ready_i,
  .fetch_valid_o,
  .fetch_addr_o, .fetch_last_o, .priority_level_o, .ack_o, .host_ack_o);

// ---- testbench/interrupt_vector_map_tb.sv ----
`timescale 1ns/1ns
module interrupt_vector_map_tb;
  logic clk_i = 1'b0, rst_i = 1'b1, ce_i = 1'b1, fetch_ready_i;
  logic [23:0] vector_base_i = 24'h000000, fetch_addr_o;
  logic [1:0]  mask_i = 2'h0, priority_level_o;
  logic [83:0] priority_level_i = '0;
  logic [41:0] pend_i = '0, ack_o;
  logic        host_pend_i = 1'b0, host_nmi_i = 1'b0, host_ack_o;
  logic        host_use_default_i = 1'b0, fetch_valid_o, fetch_last_o;
  logic [6:0]  host_vec_i = 7'h00;
  logic [3:0]  wt = 4'h0;
  int          err_total = 0, check_count = 0;
  logic [7:0]  tbl [42] = '{8'h00, 8'h02, 8'h04, 8'h06, 8'h08, 8'h0A,
    8'h10, 8'h12, 8'h14, 8'h16, 8'h18, 8'h1A, 8'h1C, 8'h1E, 8'h20, 8'h22,
    8'h64, 8'h62, 8'h60, 8'h32, 8'h30, 8'h34, 8'h38, 8'h3A, 8'h36, 8'h42,
    8'h40, 8'h44, 8'h48, 8'h4A, 8'h46, 8'h52, 8'h50, 8'h54, 8'h56, 8'h58,
    8'h26, 8'h24, 8'h2A, 8'h28, 8'h2E, 8'h2C};
  interrupt_vector_map dut_u (.clk_i, .rst_i, .ce_i, .vector_base_i,
    .mask_i, .priority_level_i, .pend_i, .host_pend_i, .host_nmi_i,
    .host_use_default_i, .host_vec_i, .fetch_ready_i, .fetch_valid_o,
    .fetch_addr_o, .fetch_last_o, .priority_level_o, .ack_o, .host_ack_o);
  pcu_model pcu_u (.clk_i, .wait_i(wt), .valid_i(fetch_valid_o),
    .ready_o(fetch_ready_i));
  initial begin
    forever #50 clk_i = ~clk_i;
  end
  task automatic stop_test();
    $display("errors %0d checks %0d", err_total, check_count);
    if (err_total == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : stop_test
  task automatic chk(input bit ok, input string m);
    check_count++;
    if (!ok) begin
      err_total++;
      $display("MISMATCH %0t %s", $time, m);
    end
  endtask : chk
  task automatic cyc(input int k);
    repeat (k) @(posedge clk_i);
    #1;
  endtask : cyc
  task automatic tick(inout int n);
    cyc(1);
    n++;
    if (n > 60) begin
      chk(1'b0, "timeout");
      stop_test();
    end
  endtask : tick
  // Wait for one taken vector, check both words, drop its request
  task automatic vec(input int i, input logic [7:0] o, input logic [1:0] l);
    logic [23:0] a;
    int n;
    a = vector_base_i + {16'h0000, o};
    n = 0;
    while (fetch_valid_o !== 1'b1) tick(n);
    chk(i < 0 ? host_ack_o === 1'b1 && ack_o === '0 :
        ack_o === 42'h1 << i && host_ack_o === 1'b0, "ack");
    chk(fetch_addr_o === a && priority_level_o === l &&
        fetch_last_o === 1'b0, "word 0");
    if (i < 0) host_pend_i = 1'b0;
    else pend_i[i] = 1'b0;
    while (fetch_last_o !== 1'b1) tick(n);
    chk(fetch_addr_o === a + 24'h1 && ack_o === '0 &&
        host_ack_o === 1'b0, "word 1");
    while (fetch_valid_o !== 1'b0) tick(n);
  endtask : vec
  task automatic s_map();
    vector_base_i = 24'h3F8101;
    for (int i = 0; i < 42; i++) priority_level_i[2*i +: 2] = 2'(i % 4);
    for (int i = 0; i < 42; i++) begin
      pend_i[i] = 1'b1;
      vec(i, tbl[i], i < 6 ? 2'h3 : 2'(i % 4 == 3 ? 2 : i % 4));
    end
  endtask : s_map
  task automatic s_prio();
    priority_level_i[83:80] = 4'hA;
    pend_i = 42'h300_0000_0042;
    vec(1, 8'h02, 2'h3);
    vec(6, 8'h10, 2'h2);
    vec(40, 8'h2E, 2'h2);
    vec(41, 8'h2C, 2'h2);
  endtask : s_prio
  task automatic s_ce();
    ce_i = 1'b0;
    pend_i[7] = 1'b1;
    cyc(5);
    chk(fetch_valid_o === 1'b0 && ack_o === '0, "frozen");
    ce_i = 1'b1;
    vec(7, 8'h12, 2'h2);
  endtask : s_ce
  task automatic s_mask();
    priority_level_i[13:12] = 2'h1;
    mask_i = 2'h1;
    pend_i[6] = 1'b1;
    cyc(20);
    chk(fetch_valid_o === 1'b0, "masked taken");
    mask_i = 2'h3;
    pend_i[3] = 1'b1;
    vec(3, 8'h06, 2'h3);
    mask_i = 2'h0;
    vec(6, 8'h10, 2'h1);
  endtask : s_mask
  task automatic s_rst();
    wt = 4'hF;
    pend_i[0] = 1'b1;
    cyc(3);
    rst_i = 1'b1;
    pend_i[0] = 1'b0;
    cyc(2);
    chk(fetch_valid_o === 1'b0 && ack_o === '0 && fetch_last_o === 1'b0 &&
        fetch_addr_o === '0 && priority_level_o === 2'h0 &&
        host_ack_o === 1'b0, "reset");
    rst_i = 1'b0;
    wt = 4'h3;
  endtask : s_rst
  task automatic s_host();
    vector_base_i = 24'hFFFF00;
    {host_pend_i, host_nmi_i, host_vec_i, mask_i} = {2'h3, 7'h06, 2'h3};
    vec(-1, 8'h0C, 2'h3);
    {host_pend_i, host_nmi_i, host_vec_i, mask_i} = {2'h2, 7'h7F, 2'h0};
    vec(-1, 8'hFE, 2'h2);
    {host_pend_i, host_use_default_i} = 2'h3;
    vec(-1, 8'h64, 2'h2);
    {host_pend_i, host_use_default_i, host_vec_i} = {2'h2, 7'h2E};
    pend_i[40] = 1'b1;
    vec(40, 8'h2E, 2'h2);
    vec(-1, 8'h5C, 2'h2);
  endtask : s_host
  initial begin
    cyc(10);
    rst_i = 1'b0;
    s_map();
    s_prio();
    s_mask();
    s_ce();
    s_rst();
    s_host();
    stop_test();
  end
endmodule : interrupt_vector_map_tb

// ---- testbench/pcu_model.sv ----
`timescale 1ns/1ns
module pcu_model (
  input  wire logic       clk_i,
  input  wire logic [3:0] wait_i,
  input  wire logic       valid_i,
  output logic            ready_o
);
  logic [3:0] cnt_q = 4'h0;
  // Accept a word after wait_i stall cycles
  assign ready_o = valid_i && (cnt_q >= wait_i);
  always @(posedge clk_i) begin
    cnt_q <= (!valid_i || ready_o) ? 4'h0 : cnt_q + 4'h1;
  end
endmodule : pcu_model
